// ==== core/flow_sched_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the scheduler.
`ifndef FLOW_SCHED_CFG_SVH
`define FLOW_SCHED_CFG_SVH
`define ADDR_CTRL 8'h00
`define ADDR_POLICY 8'h04
`define ADDR_INTERVAL 8'h08
`define ADDR_JITTER 8'h0c
`define ADDR_GRANT_SIZE 8'h10
`define ADDR_GRANTS_PER 8'h14
`define ADDR_REF_TIME 8'h18
`define ADDR_STATUS 8'h1c
`define ADDR_MASTER_TIME 8'h20
`define ADDR_MINISLOT 8'h24
`define ADDR_ISSUED 8'h28
`define CTRL_ENABLE_BIT 0
`define CTRL_TYPE_LSB 8
`define CTRL_TYPE_W 8
`define POLICY_RESET 32'h0000_0000
`define POLICY_USED_W 9
`define TYPE_RESET 8'h02
`define MINISLOT_RESET 16'h0010
`define TICKS_PER_10US 32'd1024
`define TICKS_PER_10US_W 12
`endif

// ==== core/flow_sched_pkg.sv ====
// Types shared by the flow policy and grant scheduler.
package flow_sched_pkg;
    typedef enum logic [7:0] {
        SCHED_RESERVED = 8'h00,
        SCHED_UNDEFINED = 8'h01,
        SCHED_BEST_EFFORT = 8'h02,
        SCHED_NRT_POLLING = 8'h03,
        SCHED_RT_POLLING = 8'h04,
        SCHED_GRANT_ACTIVITY = 8'h05,
        SCHED_GRANT = 8'h06
    } sched_type_e;

    typedef struct packed {
        logic drop_oversize;
        logic no_header_suppress;
        logic no_fragment;
        logic no_concatenate;
        logic no_piggyback;
        logic no_reqdata_data;
        logic no_reqdata_request;
        logic no_priority_multicast;
        logic no_broadcast;
    } policy_s;

    typedef struct packed {
        logic is_poll;
        logic [6:0] index;
        logic [15:0] minislots;
        logic [31:0] time_stamp;
    } grant_s;
endpackage

// ==== core/us_to_ticks.sv ====
// Converts a microsecond figure to 10.24 MHz master clock ticks.
`timescale 1ns/10ps
`include "flow_sched_cfg.svh"
module us_to_ticks (
    // Clocking
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Conversion
    input wire logic [31:0] us_i,
    output logic [31:0] ticks_o
);
    logic [43:0] prod;

    // Ticks are us * 1024 / 100; the integer part is kept so that an
    // ideal time never runs ahead of its true value.
    assign prod = 44'(us_i) *
        44'(`TICKS_PER_10US);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ticks_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ticks_o <= 32'(prod / 44'd100);
        end
    end
endmodule

// ==== core/flow_sched.sv ====
// Per-flow upstream policy decoding and periodic poll or grant scheduling.
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`include "flow_sched_cfg.svh"
module flow_sched (
    // Clocking
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Classic Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // Master clock tick, one cycle per 10.24 MHz edge
    input wire logic mclk_tick_i,
    // Activity detection: number of currently active sessions
    input wire logic [6:0] active_grants_i,
    // Upstream slot allocator
    output logic grant_valid_o,
    output flow_sched_pkg::grant_s grant_o,
    input wire logic grant_ready_i,
    // Decoded policy for the modem side configuration
    output flow_sched_pkg::policy_s policy_o,
    output logic [15:0] grant_size_o
);
    logic enable_q;
    logic [7:0] sched_type_q;
    logic [31:0] policy_q;
    logic [31:0] interval_q;
    logic [31:0] jitter_q;
    logic [15:0] grant_size_q;
    logic [6:0] grants_per_q;
    logic [31:0] ref_time_q;
    logic [15:0] minislot_q;
    logic [31:0] master_time_q;
    logic [31:0] next_ideal_q;
    logic [31:0] deadline_q;
    logic [6:0] issued_q;
    logic [6:0] target_q;
    logic [31:0] issued_total_q;
    logic late_q;
    logic ref_load_q;
    logic [31:0] interval_ticks;
    logic [31:0] jitter_ticks;
    logic [31:0] slot_gap;
    logic [31:0] slot_time;
    logic [31:0] since_ideal;
    logic [31:0] stamp_d;
    logic [6:0] target_d;
    logic [15:0] slots_d;
    logic is_grant_flow;
    logic is_poll_flow;
    logic period_due;
    logic slot_due;
    logic period_done;
    logic wr;
    logic rd_ok;
    logic [31:0] wdata;
    logic [31:0] rdata;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_ISSUE
    } state_e;
    state_e state_q;

    us_to_ticks u_interval (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .us_i(interval_q),
        .ticks_o(interval_ticks)
    );

    assign is_grant_flow =
        sched_type_q == flow_sched_pkg::SCHED_GRANT ||
        sched_type_q == flow_sched_pkg::SCHED_GRANT_ACTIVITY;
    assign is_poll_flow =
        sched_type_q == flow_sched_pkg::SCHED_NRT_POLLING ||
        sched_type_q == flow_sched_pkg::SCHED_RT_POLLING;

    // Jitter ticks, rounded down so the deadline never exceeds the bound.
    us_to_ticks u_jitter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .us_i(jitter_q),
        .ticks_o(jitter_ticks)
    );

    // policy bits decoded, one enables each restriction
    always_comb begin
        policy_o.no_broadcast = policy_q[0];
        policy_o.no_priority_multicast = policy_q[1];
        policy_o.no_reqdata_request = policy_q[2];
        policy_o.no_reqdata_data = policy_q[3];
        policy_o.no_piggyback = policy_q[4];
        policy_o.no_concatenate = policy_q[5];
        policy_o.no_fragment = policy_q[6];
        policy_o.no_header_suppress = policy_q[7];
        // drop bit only for plain service
        policy_o.drop_oversize = policy_q[8] &&
            sched_type_q == flow_sched_pkg::SCHED_GRANT;
    end
    // grant size is the whole MAC frame byte count
    assign grant_size_o = grant_size_q;

    always_comb begin
        if (minislot_q == 16'h0000) begin
            slots_d = 16'h0000;
        end else begin
            slots_d = 16'((17'(grant_size_q) + 17'(minislot_q) -
                17'h00001) / 17'(minislot_q));
        end
    end

    // activity mode caps count at active sessions
    always_comb begin
        target_d = grants_per_q;
        if (sched_type_q == flow_sched_pkg::SCHED_GRANT_ACTIVITY &&
                active_grants_i < grants_per_q) begin
            target_d = active_grants_i;
        end
        if (is_poll_flow) begin
            target_d = 7'h01;
        end
    end

    // grants within one interval spread evenly over the jitter
    assign slot_gap = (target_q > 7'h01) ?
        jitter_ticks / 32'(target_q - 7'h01) : 32'h0000_0000;
    assign slot_time = next_ideal_q + 32'(slot_gap * 32'(issued_q));
    assign since_ideal = master_time_q - next_ideal_q;
    assign period_due = since_ideal[31] == 1'b0;
    assign slot_due = (master_time_q - slot_time) < 32'h8000_0000;
    assign period_done = issued_q >= target_q;

    // 32-bit count of the 10.24 MHz master clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_time_q <= 32'h0000_0000;
        end else if (ce_i && mclk_tick_i) begin
            master_time_q <= master_time_q + 32'h0000_0001;
        end
    end

    // stamps taken from the master clock count
    assign stamp_d = master_time_q;

    // Wishbone decode: single-cycle ack, unmapped addresses answer err.
    assign wdata = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
        {8{sel_i[0]}}} & dat_i;
    always_comb begin
        rd_ok = 1'b1;
        rdata = 32'h0000_0000;
        case (adr_i)
            `ADDR_CTRL: rdata = {16'h0000, sched_type_q, 7'h00, enable_q};
            // reserved bits held as written, never decoded
            `ADDR_POLICY: rdata = policy_q;
            `ADDR_INTERVAL: rdata = interval_q;
            `ADDR_JITTER: rdata = jitter_q;
            `ADDR_GRANT_SIZE: rdata = {16'h0000, grant_size_q};
            `ADDR_GRANTS_PER: rdata = {25'h0000000, grants_per_q};
            `ADDR_REF_TIME: rdata = ref_time_q;
            `ADDR_STATUS: rdata = {late_q, 5'h00, state_q, 8'h00,
                issued_q, 1'b0, target_q, 1'b0};
            `ADDR_MASTER_TIME: rdata = master_time_q;
            `ADDR_MINISLOT: rdata = {16'h0000, minislot_q};
            `ADDR_ISSUED: rdata = issued_total_q;
            default: rd_ok = 1'b0;
        endcase
    end
    // A write lands on the edge at which the master sees ack high.
    assign wr = cyc_i && stb_i && we_i && ack_o && rd_ok;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_o <= cyc_i && stb_i && !ack_o && !err_o && rd_ok;
            err_o <= cyc_i && stb_i && !ack_o && !err_o && !rd_ok;
            dat_o <= rdata;
        end
    end

    // policy defaults to zero for best effort
    // other types rely on software writing it
    // grant parameters held only in this block
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_q <= 1'b0;
            sched_type_q <= `TYPE_RESET;
            policy_q <= `POLICY_RESET;
            interval_q <= 32'h0000_0000;
            jitter_q <= 32'h0000_0000;
            grant_size_q <= 16'h0000;
            grants_per_q <= 7'h00;
            ref_time_q <= 32'h0000_0000;
            minislot_q <= `MINISLOT_RESET;
        end else if (ce_i && wr) begin
            case (adr_i)
                `ADDR_CTRL: begin
                    enable_q <= wdata[`CTRL_ENABLE_BIT];
                    sched_type_q <= wdata[`CTRL_TYPE_LSB +:
                        `CTRL_TYPE_W];
                end
                `ADDR_POLICY: policy_q <= wdata;
                `ADDR_INTERVAL: interval_q <= wdata;
                `ADDR_JITTER: jitter_q <= wdata;
                `ADDR_GRANT_SIZE: grant_size_q <= wdata[15:0];
                `ADDR_GRANTS_PER: grants_per_q <= wdata[6:0];
                `ADDR_REF_TIME: ref_time_q <= wdata;
                `ADDR_MINISLOT: minislot_q <= wdata[15:0];
                default: ;
            endcase
        end
    end

    // A reference write restarts the schedule from the new t0, except when it lands while in ST_ISSUE.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_load_q <= 1'b0;
        end else if (ce_i) begin
            ref_load_q <= wr && adr_i == `ADDR_REF_TIME;
        end
    end

    // Scheduler: wait for the ideal time, issue the period's opportunities,
    // then advance the ideal time by one interval.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            next_ideal_q <= 32'h0000_0000;
            deadline_q <= 32'h0000_0000;
            issued_q <= 7'h00;
            target_q <= 7'h00;
        end else if (ce_i) begin
            case (state_q)
                ST_IDLE: begin
                    issued_q <= 7'h00;
                    if (enable_q && (is_grant_flow || is_poll_flow)) begin
                        next_ideal_q <= ref_time_q;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!enable_q || ref_load_q) begin
                        state_q <= ST_IDLE;
                    end else if (period_due) begin
                        target_q <= target_d;
                        issued_q <= 7'h00;
                        deadline_q <= next_ideal_q + jitter_ticks;
                        state_q <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    if (!enable_q) begin
                        state_q <= ST_IDLE;
                    end else if (period_done) begin
                        // advance ideal time by one interval
                        next_ideal_q <= next_ideal_q + interval_ticks;
                        state_q <= ST_WAIT;
                    end else if (grant_valid_o && grant_ready_i) begin
                        issued_q <= issued_q + 7'h01;
                    end else if ((master_time_q - deadline_q) <
                            32'h8000_0000 && master_time_q !=
                            deadline_q) begin
                        // Past the jitter bound: give the period up rather
                        // than place an opportunity outside the window.
                        issued_q <= target_q;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Late flag: set when a period's opportunities are abandoned.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            late_q <= 1'b0;
            issued_total_q <= 32'h0000_0000;
        end else if (ce_i) begin
            if (state_q == ST_ISSUE && !period_done && !grant_valid_o &&
                    (master_time_q - deadline_q) < 32'h8000_0000 &&
                    master_time_q != deadline_q) begin
                late_q <= 1'b1;
            end else if (wr && adr_i == `ADDR_STATUS) begin
                late_q <= 1'b0;
            end
            if (grant_valid_o && grant_ready_i) begin
                issued_total_q <= issued_total_q + 32'h0000_0001;
            end
        end
    end

    // Opportunity offered while within the window and its slot is due.
    assign grant_valid_o = state_q == ST_ISSUE && !period_done &&
        enable_q && slot_due && (deadline_q - master_time_q) <
        32'h8000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            grant_o <= '0;
        end else if (ce_i) begin
            grant_o.is_poll <= is_poll_flow;
            grant_o.index <= (grant_valid_o && grant_ready_i) ?
                issued_q + 7'h01 : issued_q;
            grant_o.minislots <= is_poll_flow ? 16'h0001 : slots_d;
            grant_o.time_stamp <= stamp_d;
        end
    end
endmodule

// ==== sim/flow_sched_properties.sv ====
// Port-level assertions for the flow scheduler, bound to every instance.
`timescale 1ns/10ps
module flow_sched_properties (
    // Clocking
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    input wire logic err_o,
    // Scheduling
    input wire logic grant_valid_o,
    input wire flow_sched_pkg::grant_s grant_o,
    input wire logic grant_ready_i,
    input wire flow_sched_pkg::policy_s policy_o,
    input wire logic [15:0] grant_size_o
);
    logic [7:0] type_q;
    logic en_q;
    logic wr;
    logic take;
    assign wr = ack_o && we_i;
    assign take = grant_valid_o && grant_ready_i;
    // A shadow of the control word, since type and enable are not ports.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            type_q <= 8'h02;
            en_q <= 1'b0;
        end else if (wr && adr_i == 8'h00 && sel_i == 4'hf) begin
            type_q <= dat_i[15:8];
            en_q <= dat_i[0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_BUS_ANSWER: assert property (
        cyc_i && stb_i && !ack_o && !err_o |=> ack_o ^ err_o)
        else $error("bus request not answered in one cycle");
    AST_ACK_PULSE: assert property (ack_o || err_o |=> !ack_o && !err_o)
        else $error("bus answer longer than one cycle");
    AST_POLICY_BITS: assert property (
        wr && adr_i == 8'h04 && sel_i == 4'hf
        |=> policy_o[7:0] == $past(dat_i[7:0]))
        else $error("policy bits differ from written word");
    AST_DROP_TYPE: assert property (
        policy_o.drop_oversize |-> type_q == 8'h06 || wr && adr_i == 8'h00)
        else $error("drop bit active outside grant service");
    AST_SIZE_WRITE: assert property (
        wr && adr_i == 8'h10 && sel_i == 4'hf
        |=> grant_size_o == $past(dat_i[15:0]))
        else $error("grant size differs from written value");
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        rst_i |=> !ack_o && !err_o && !grant_valid_o && policy_o == '0)
        else $error("outputs active after reset");
    AST_IDLE_OFF: assert property (!en_q && !ack_o |-> !grant_valid_o)
        else $error("opportunity offered while disabled");
    AST_POLL_KIND: assert property (
        take |-> grant_o.is_poll == (type_q inside {8'h03, 8'h04}))
        else $error("poll flag does not match scheduling type");
    COV_POLL: cover property (take && grant_o.is_poll);
    COV_GRANT: cover property (take && !grant_o.is_poll);
    COV_ERR: cover property (err_o);
endmodule
bind flow_sched flow_sched_properties u_props (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .ack_o(ack_o), .err_o(err_o), .grant_valid_o(grant_valid_o),
    .grant_o(grant_o), .grant_ready_i(grant_ready_i),
    .policy_o(policy_o), .grant_size_o(grant_size_o)
);

// ==== sim/grant_sink.sv ====
// Modem-side model that takes opportunities and obeys the decoded policy.
`timescale 1ns/10ps
module grant_sink (
    // Clocking
    input wire logic clk_i,
    input wire logic rst_i,
    // Opportunities
    input wire logic slow_i,
    output logic grant_ready_o,
    // Policy
    input wire flow_sched_pkg::policy_s policy_i,
    output logic [7:0] may_use_o,
    output logic drop_big_o
);
    logic phase_q;
    // Slow mode stalls every other cycle, as a busy allocator would.
    always_ff @(posedge clk_i) begin
        phase_q <= rst_i ? 1'b0 : !phase_q;
    end
    assign grant_ready_o = !slow_i || phase_q;
    assign may_use_o = ~policy_i[7:0];
    assign drop_big_o = policy_i.drop_oversize;
endmodule

// ==== sim/flow_sched_test.sv ====
// Self-checking bench for the flow policy and grant scheduler.
`timescale 1ns/10ps
module flow_sched_test;
    logic clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0, mclk_tick_i = 1'b0;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, tk = 32'h0, cyc_n = 32'h0;
    logic [6:0] active_grants_i = 7'h00;
    logic ack_o, err_o, grant_valid_o, grant_ready_i, drop_big;
    logic [7:0] may_use;
    logic [15:0] grant_size_o;
    flow_sched_pkg::grant_s grant_o;
    flow_sched_pkg::policy_s policy_o;
    logic [31:0] gq[$];
    logic pq[$];
    int failures = 0;
    int compares = 0;
    flow_sched u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
        .mclk_tick_i(mclk_tick_i), .active_grants_i(active_grants_i),
        .grant_valid_o(grant_valid_o), .grant_o(grant_o),
        .grant_ready_i(grant_ready_i), .policy_o(policy_o),
        .grant_size_o(grant_size_o)
    );
    grant_sink u_sink (
        .clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
        .grant_ready_o(grant_ready_i), .policy_i(policy_o),
        .may_use_o(may_use), .drop_big_o(drop_big)
    );
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // Ticks skip one cycle in eight so master time and bus cycles drift.
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 32'h1;
        mclk_tick_i <= cyc_n[2:0] != 3'h7;
        tk <= rst_i ? 32'h0 : tk + {31'h0, mclk_tick_i};
        if (!rst_i && grant_valid_o === 1'b1 && grant_ready_i === 1'b1) begin
            gq.push_back(tk);
            pq.push_back(grant_o.is_poll);
        end
        if (cyc_n == 32'd40000) begin
            failures++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [3:0] s, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
        q = dat_o;
        e = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        bus(1'b1, a, 4'hf, d, q, e);
    endtask
    task automatic pchk(input string name, input logic [31:0] exp);
        @(negedge clk_i);
        chk(name, exp, {23'h0, policy_o});
        chk("may use", {24'h0, ~exp[7:0]}, {24'h0, may_use});
        chk("drop big", {31'h0, exp[8]}, {31'h0, drop_big});
    endtask
    task automatic t_reset();
        logic [31:0] q;
        logic e;
        bus(1'b0, 8'h00, 4'hf, 32'h0, q, e);
        chk("ctrl reset", 32'h0000_0200, q);
        bus(1'b0, 8'h04, 4'hf, 32'h0, q, e);
        chk("policy reset", 32'h0, q);
        bus(1'b0, 8'h24, 4'hf, 32'h0, q, e);
        chk("minislot reset", 32'h0000_0010, q);
        bus(1'b1, 8'h40, 4'hf, 32'h1, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
    endtask
    task automatic t_policy();
        logic [31:0] q;
        logic e;
        for (int t = 3; t < 7; t++) begin
            wr(8'h00, {16'h0, t[7:0], 8'h00});
            for (int k = 0; k < 9; k++) begin
                wr(8'h04, 32'h1 << k);
                pchk("policy bit", (k == 8 && t != 6) ? 0 : 32'h1 << k);
            end
            wr(8'h04, 32'hffff_fe00);
            pchk("reserved bits", 32'h0);
        end
        bus(1'b1, 8'h04, 4'h2, 32'h0000_01ff, q, e);
        pchk("byte lane", 32'h0000_0100);
    endtask
    task automatic t_sched(input logic [7:0] ty, input logic [6:0] n,
        input logic [6:0] act, input logic sl, input int want);
        int per;
        int jit;
        int cnt[3];
        logic [31:0] t0;
        logic [31:0] off;
        logic [31:0] slots;
        per = 100 * 1024 / 100;
        jit = 20 * 1024 / 100;
        cnt = '{0, 0, 0};
        slow <= sl;
        active_grants_i <= act;
        wr(8'h00, {16'h0, ty, 8'h00});
        wr(8'h04, 32'h0);
        wr(8'h08, 32'd100);
        wr(8'h0c, 32'd20);
        wr(8'h10, 32'h0000_0064);
        wr(8'h14, {25'h0, n});
        t0 = tk + 32'd64;
        wr(8'h18, t0);
        wr(8'h00, {16'h0, ty, 8'h01});
        gq.delete();
        pq.delete();
        while (tk < t0 + 3 * per) @(posedge clk_i);
        wr(8'h00, {16'h0, ty, 8'h00});
        chk("grant size", 32'h0000_0064, {16'h0, grant_size_o});
        // A 100-byte grant over 16-byte minislots needs 7 of them.
        slots = (ty < 8'h05) ? 32'h1 : 32'h7;
        chk("minislots", slots, {16'h0, grant_o.minislots});
        foreach (gq[i]) begin
            off = gq[i] - t0;
            if (off < 3 * per) begin
                cnt[off / per]++;
                chk("in window", 32'h1, {31'h0, off % per <= jit});
                chk("poll flag", {31'h0, ty < 8'h05}, {31'h0, pq[i]});
            end
        end
        for (int p = 0; p < 3; p++) begin
            chk("per period", want, cnt[p]);
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_policy();
        t_sched(8'h06, 7'd3, 7'd0, 1'b0, 3);
        t_sched(8'h05, 7'd3, 7'd1, 1'b0, 1);
        t_sched(8'h03, 7'd1, 7'd0, 1'b1, 1);
        end_sim();
    end
endmodule
